// ---- hw/i2c_pkg.sv ----
package i2c_pkg;

  // Register port map, byte-wide registers; the control word has a set port and a clear port
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_CONTROL_SET_PORT = 4'h0;
  localparam logic [3:0] REG_CONDITION_CODE = 4'h1;
  localparam logic [3:0] REG_SHIFT_BYTE = 4'h2;
  localparam logic [3:0] REG_LOW_PERIOD_COUNT = 4'h3;
  localparam logic [3:0] REG_HIGH_PERIOD_COUNT = 4'h4;
  localparam logic [3:0] REG_OWN_ADDRESS = 4'h5;
  localparam logic [3:0] REG_CONTROL_CLEAR_PORT = 4'h6;

  // Control word fields
  localparam int BIT_BUS_ENABLE = 6;
  localparam int BIT_BEGIN_REQUEST = 5;
  localparam int BIT_HALT_REQUEST = 4;
  localparam int BIT_INT_FLAG = 3;
  localparam int BIT_ACK_ASSERT = 2;
  localparam logic [7:0] CONTROL_MASK = 8'h7C;

  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] LOW_PERIOD_RESET = 8'h04;
  localparam logic [7:0] HIGH_PERIOD_RESET = 8'h04;
  localparam logic [7:0] OWN_ADDRESS_RESET = 8'h00;
  localparam logic [7:0] SHIFT_BYTE_RESET = 8'h00;

  // Input filter depth in clock cycles
  localparam int FILTER_LEN = 3;

  // Condition codes, five bits; the register shows them times eight
  localparam logic [4:0] CODE_START = 5'h01;
  localparam logic [4:0] CODE_RSTART = 5'h02;
  localparam logic [4:0] CODE_TX_ADDR_ACK = 5'h03;
  localparam logic [4:0] CODE_TX_ADDR_NACK = 5'h04;
  localparam logic [4:0] CODE_TX_DATA_ACK = 5'h05;
  localparam logic [4:0] CODE_TX_DATA_NACK = 5'h06;
  localparam logic [4:0] CODE_ARB_LOST = 5'h07;
  localparam logic [4:0] CODE_RX_ADDR_ACK = 5'h08;
  localparam logic [4:0] CODE_RX_ADDR_NACK = 5'h09;
  localparam logic [4:0] CODE_RX_DATA_ACK = 5'h0A;
  localparam logic [4:0] CODE_RX_DATA_NACK = 5'h0B;
  localparam logic [4:0] CODE_SLV_W_LOST = 5'h0D;
  localparam logic [4:0] CODE_GCALL_LOST = 5'h0F;
  localparam logic [4:0] CODE_SLV_R_LOST = 5'h16;
  localparam logic [4:0] CODE_IDLE = 5'h1F;

  localparam logic [3:0] ACK_BIT = 4'h8;

  typedef enum logic [2:0] {
    PH_LOW = 3'b001,
    PH_WAIT = 3'b010,
    PH_HIGH = 3'b100
  } phase_t;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_START = 9'h002,
    ST_HOLD = 9'h004,
    ST_XFER = 9'h008,
    ST_STOP_LO = 9'h010,
    ST_STOP_HI = 9'h020,
    ST_RS_LO = 9'h040,
    ST_RS_HI = 9'h080,
    ST_SLAVE = 9'h100
  } ctl_state_t;

  // A phase of lim cycles, at least one, is over
  function automatic logic period_done(input logic [7:0] cnt, input logic [7:0] lim);
    period_done = ({1'b0, cnt} + 9'h001) >= {1'b0, lim};
  endfunction

endpackage

// ---- hw/scl_gen_if.sv ----
`timescale 1ns/1ps
interface scl_gen_if;
  logic en;
  logic hold;
  logic scl_line;
  logic [7:0] low_cnt;
  logic [7:0] high_cnt;
  logic drive_low;
  logic rise_evt;
  logic fall_evt;
  modport gen (input en, input hold, input scl_line, input low_cnt, input high_cnt,
               output drive_low, output rise_evt, output fall_evt);
  modport ctl (output en, output hold, output scl_line, output low_cnt, output high_cnt,
               input drive_low, input rise_evt, input fall_evt);
endinterface

// ---- hw/glitch_filter.sv ----
`timescale 1ns/1ps
module glitch_filter
  import i2c_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Line in and filtered level out
  input wire logic raw,
  output logic filt
);

  logic meta_q;
  logic sync_q;
  logic [FILTER_LEN-1:0] hist_q;
  logic filt_q;
  wire all_one = &hist_q;
  wire all_zero = ~|hist_q;

  // Idle bus is high, so everything resets high
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      hist_q <= '1;
      filt_q <= 1'b1;
    end else begin
      meta_q <= raw;
      sync_q <= meta_q;
      hist_q <= {hist_q[FILTER_LEN-2:0], sync_q};
      if (all_one) begin
        filt_q <= 1'b1;
      end else if (all_zero) begin
        filt_q <= 1'b0;
      end
    end
  end

  assign filt = filt_q;

  flt_agree_a: assert property (@(posedge clk) disable iff (sys_rst)
    (filt != $past(filt)) |-> ($past(hist_q) == {FILTER_LEN{filt}}))
    else $error("filtered level changed without three equal samples");

endmodule

// ---- hw/scl_clock_gen.sv ----
`timescale 1ns/1ps
module scl_clock_gen
  import i2c_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Controller side
  scl_gen_if.gen cg
);

  phase_t ph_q;
  phase_t ph_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;

  wire low_over = period_done(cnt_q, cg.low_cnt);
  wire high_over = period_done(cnt_q, cg.high_cnt);

  always_comb begin
    ph_d = ph_q;
    cnt_d = cnt_q + 8'h01;
    if (!cg.en) begin
      ph_d = PH_LOW;
      cnt_d = 8'h00;
    end else begin
      case (ph_q)
        PH_LOW: begin
          if (cg.hold) begin
            cnt_d = 8'h00;
          // Own low reaches the filtered line late; leaving earlier reads the old high as a release
          end else if (low_over && !cg.scl_line) begin
            ph_d = PH_WAIT;
            cnt_d = 8'h00;
          end
        end
        PH_WAIT: begin
          // Another party may keep the line low as long as it likes
          cnt_d = 8'h00;
          if (cg.scl_line) begin
            ph_d = PH_HIGH;
          end
        end
        PH_HIGH: begin
          if (!cg.scl_line || high_over) begin
            ph_d = PH_LOW;
            cnt_d = 8'h00;
          end
        end
        default: begin
          ph_d = PH_LOW;
          cnt_d = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ph_q <= PH_LOW;
      cnt_q <= 8'h00;
    end else begin
      ph_q <= ph_d;
      cnt_q <= cnt_d;
    end
  end

  assign cg.drive_low = cg.en && (ph_q == PH_LOW);
  assign cg.rise_evt = cg.en && (ph_q == PH_WAIT) && cg.scl_line;
  assign cg.fall_evt = cg.en && (ph_q == PH_HIGH) && (ph_d == PH_LOW);

  sync_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
    cg.en && ph_q == PH_WAIT && !cg.scl_line |=> ph_q != PH_HIGH)
    else $error("high phase began while the line was still low");

  early_end_a: assert property (@(posedge clk) disable iff (sys_rst)
    cg.en && ph_q == PH_HIGH && !cg.scl_line |=> ph_q == PH_LOW)
    else $error("high phase not cut short by a low line");

  low_time_a: assert property (@(posedge clk) disable iff (sys_rst)
    cg.en && !cg.hold && ph_q == PH_LOW && cnt_q < cg.low_cnt && cnt_q != 8'hFF && !low_over
      |=> ph_q == PH_LOW)
    else $error("low phase shorter than programmed");

endmodule

// ---- hw/i2c_arbitration_sync_control.sv ----
`timescale 1ns/1ps
module i2c_arbitration_sync_control
  import i2c_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Serial clock pin
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  // Serial data pin
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);

  scl_gen_if cg ();

  logic scl_f;
  logic sda_f;
  logic scl_p_q;
  logic sda_p_q;
  logic busy_q;
  logic [7:0] ctl_q;
  logic [7:0] ctl_d;
  logic [7:0] low_q;
  logic [7:0] high_q;
  logic [7:0] own_q;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [4:0] code_q;
  logic [4:0] code_d;
  ctl_state_t st_q;
  ctl_state_t st_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [3:0] bit_q;
  logic [3:0] bit_d;
  logic rx_q;
  logic rx_d;
  logic first_q;
  logic first_d;
  logic lost_q;
  logic lost_d;
  logic rs_q;
  logic rs_d;
  logic rel_q;
  logic rel_d;
  logic ack_q;
  logic ack_d;
  logic si_set;
  logic halt_done;
  logic [7:0] rdata_q;
  logic scl_oe_q;
  logic sda_oe_q;
  logic scl_out_q;
  logic sda_out_q;

  glitch_filter u_scl_filter (
    .clk(clk),
    .sys_rst(sys_rst),
    .raw(scl_in),
    .filt(scl_f)
  );

  glitch_filter u_sda_filter (
    .clk(clk),
    .sys_rst(sys_rst),
    .raw(sda_in),
    .filt(sda_f)
  );

  scl_clock_gen u_clock_gen (
    .clk(clk),
    .sys_rst(sys_rst),
    .cg(cg)
  );

  // Register port decode
  wire wr_set = reg_wr && (reg_addr == REG_CONTROL_SET_PORT);
  wire wr_clr = reg_wr && (reg_addr == REG_CONTROL_CLEAR_PORT);
  wire wr_shift = reg_wr && (reg_addr == REG_SHIFT_BYTE);
  wire wr_low = reg_wr && (reg_addr == REG_LOW_PERIOD_COUNT);
  wire wr_high = reg_wr && (reg_addr == REG_HIGH_PERIOD_COUNT);
  wire wr_own = reg_wr && (reg_addr == REG_OWN_ADDRESS);
  wire si_q = ctl_q[BIT_INT_FLAG];
  wire [7:0] status_val = si_q ? {code_q, 3'b000} : {CODE_IDLE, 3'b000};
  wire [7:0] rd_val =
    (reg_addr == REG_CONTROL_SET_PORT) ? ctl_q :
    (reg_addr == REG_CONDITION_CODE) ? status_val :
    (reg_addr == REG_SHIFT_BYTE) ? shift_q :
    (reg_addr == REG_LOW_PERIOD_COUNT) ? low_q :
    (reg_addr == REG_HIGH_PERIOD_COUNT) ? high_q :
    (reg_addr == REG_OWN_ADDRESS) ? own_q : 8'h00;

  // Bus condition detection on filtered lines
  wire start_det = scl_f && scl_p_q && sda_p_q && !sda_f;
  wire stop_det = scl_f && scl_p_q && !sda_p_q && sda_f;
  wire go = ctl_q[BIT_BUS_ENABLE] && ctl_q[BIT_BEGIN_REQUEST] && !si_q && !busy_q;
  wire rise = cg.rise_evt && (st_q == ST_XFER);
  wire fall = cg.fall_evt && (st_q == ST_XFER);
  wire data_rx = rx_q && !first_q;
  wire released = !sda_oe_q;
  wire arb_tx_lost = rise && !data_rx && !lost_q && (bit_q < ACK_BIT) && released && !sda_f;
  wire arb_rx_lost = rise && data_rx && !lost_q && (bit_q == ACK_BIT) && released && !sda_f;
  wire own_match = shift_q[7:1] == own_q[7:1];
  wire gcall_match = own_q[0] && (shift_q == 8'h00);
  wire slave_ok = first_q && ctl_q[BIT_ACK_ASSERT] && (own_match || gcall_match);
  wire ack_rel = lost_q ? !slave_ok : (data_rx ? !ctl_q[BIT_ACK_ASSERT] : 1'b1);
  wire [4:0] lost_code = !rel_q ? (gcall_match ? CODE_GCALL_LOST :
                         (shift_q[0] ? CODE_SLV_R_LOST : CODE_SLV_W_LOST)) : CODE_ARB_LOST;
  wire [4:0] byte_code = first_q ?
    (shift_q[0] ? (ack_q ? CODE_RX_ADDR_ACK : CODE_RX_ADDR_NACK)
                : (ack_q ? CODE_TX_ADDR_ACK : CODE_TX_ADDR_NACK)) :
    (rx_q ? (rel_q ? CODE_RX_DATA_NACK : CODE_RX_DATA_ACK)
          : (ack_q ? CODE_TX_DATA_ACK : CODE_TX_DATA_NACK));
  wire scl_low_want =
    ((st_q == ST_XFER) || (st_q == ST_HOLD)) ? cg.drive_low :
    ((st_q == ST_STOP_LO) || (st_q == ST_RS_LO)) ? 1'b1 :
    (st_q == ST_SLAVE) ? si_q : 1'b0;
  // During a transfer, data may only move while our own clock low is already on the wire
  wire sda_oe_d = ((st_q == ST_XFER) && !scl_oe_q) ? sda_oe_q : !rel_q;

  assign cg.en = (st_q == ST_XFER) || (st_q == ST_HOLD);
  assign cg.hold = (st_q == ST_HOLD);
  assign cg.scl_line = scl_f;
  assign cg.low_cnt = low_q;
  assign cg.high_cnt = high_q;

  // Shift register: software load, bus bits enter at the right
  assign shift_d = wr_shift ? reg_wdata :
                   (rise && (bit_q < ACK_BIT)) ? {shift_q[6:0], sda_f} : shift_q;

  // Control word; the hardware flag set is applied last so it wins
  always_comb begin
    ctl_d = ctl_q;
    if (halt_done) begin
      ctl_d[BIT_HALT_REQUEST] = 1'b0;
    end
    if (wr_set) begin
      ctl_d = ctl_d | (reg_wdata & CONTROL_MASK);
    end
    if (wr_clr) begin
      ctl_d = ctl_d & ~(reg_wdata & CONTROL_MASK);
    end
    if (si_set) begin
      ctl_d[BIT_INT_FLAG] = 1'b1;
    end
  end

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    bit_d = bit_q;
    rx_d = rx_q;
    first_d = first_q;
    lost_d = lost_q;
    rs_d = rs_q;
    rel_d = rel_q;
    ack_d = ack_q;
    code_d = code_q;
    si_set = 1'b0;
    halt_done = 1'b0;
    case (st_q)
      ST_IDLE: begin
        rel_d = 1'b1;
        cnt_d = 8'h00;
        if (go) begin
          st_d = ST_START;
        end
      end
      ST_START: begin
        rel_d = 1'b0;
        cnt_d = cnt_q + 8'h01;
        if (period_done(cnt_q, high_q)) begin
          st_d = ST_HOLD;
          si_set = 1'b1;
          code_d = rs_q ? CODE_RSTART : CODE_START;
          first_d = 1'b1;
          rx_d = 1'b0;
          lost_d = 1'b0;
          rs_d = 1'b0;
        end
      end
      ST_HOLD: begin
        cnt_d = 8'h00;
        if (!si_q) begin
          if (ctl_q[BIT_HALT_REQUEST]) begin
            st_d = ST_STOP_LO;
          end else if (ctl_q[BIT_BEGIN_REQUEST]) begin
            st_d = ST_RS_LO;
          end else begin
            st_d = ST_XFER;
            bit_d = 4'h0;
            rel_d = data_rx ? 1'b1 : shift_q[7];
          end
        end
      end
      ST_XFER: begin
        if (arb_tx_lost || arb_rx_lost) begin
          lost_d = 1'b1;
        end
        if (rise && (bit_q == ACK_BIT)) begin
          ack_d = !sda_f;
        end
        if (fall && (bit_q == ACK_BIT)) begin
          si_set = 1'b1;
          first_d = 1'b0;
          if (lost_q) begin
            st_d = ST_SLAVE;
            rel_d = !rel_q ? 1'b0 : 1'b1;
            code_d = lost_code;
          end else begin
            st_d = ST_HOLD;
            code_d = byte_code;
            rx_d = first_q ? shift_q[0] : rx_q;
          end
        end else if (fall) begin
          bit_d = bit_q + 4'h1;
          rel_d = (bit_q == 4'h7) ? ack_rel : ((lost_q || data_rx) ? 1'b1 : shift_q[7]);
        end
      end
      ST_STOP_LO: begin
        rel_d = 1'b0;
        cnt_d = cnt_q + 8'h01;
        if (period_done(cnt_q, low_q)) begin
          st_d = ST_STOP_HI;
          cnt_d = 8'h00;
        end
      end
      ST_STOP_HI: begin
        cnt_d = scl_f ? cnt_q + 8'h01 : 8'h00;
        if (scl_f && period_done(cnt_q, high_q)) begin
          st_d = ST_IDLE;
          rel_d = 1'b1;
          halt_done = 1'b1;
        end
      end
      ST_RS_LO: begin
        rel_d = 1'b1;
        cnt_d = cnt_q + 8'h01;
        if (period_done(cnt_q, low_q)) begin
          st_d = ST_RS_HI;
          cnt_d = 8'h00;
        end
      end
      ST_RS_HI: begin
        cnt_d = scl_f ? cnt_q + 8'h01 : 8'h00;
        if (scl_f && period_done(cnt_q, high_q)) begin
          st_d = ST_START;
          cnt_d = 8'h00;
          rs_d = 1'b1;
        end
      end
      ST_SLAVE: begin
        // Further slave bytes are handled elsewhere; the ack is held only while flagged
        if (!si_q) begin
          st_d = ST_IDLE;
          rel_d = 1'b1;
        end
      end
      default: begin
        st_d = ST_IDLE;
        rel_d = 1'b1;
      end
    endcase
    if (!ctl_q[BIT_BUS_ENABLE]) begin
      st_d = ST_IDLE;
      rel_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_q <= CONTROL_RESET;
      low_q <= LOW_PERIOD_RESET;
      high_q <= HIGH_PERIOD_RESET;
      own_q <= OWN_ADDRESS_RESET;
      shift_q <= SHIFT_BYTE_RESET;
    end else begin
      ctl_q <= ctl_d;
      shift_q <= shift_d;
      if (wr_low) begin
        low_q <= reg_wdata;
      end
      if (wr_high) begin
        high_q <= reg_wdata;
      end
      if (wr_own) begin
        own_q <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
      cnt_q <= 8'h00;
      bit_q <= 4'h0;
      rx_q <= 1'b0;
      first_q <= 1'b0;
      lost_q <= 1'b0;
      rs_q <= 1'b0;
      rel_q <= 1'b1;
      ack_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      rx_q <= rx_d;
      first_q <= first_d;
      lost_q <= lost_d;
      rs_q <= rs_d;
      rel_q <= rel_d;
      ack_q <= ack_d;
    end
  end

  // Code moves only when the flag is raised by hardware
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      code_q <= CODE_IDLE;
    end else if (si_set) begin
      code_q <= code_d;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
      if (start_det) begin
        busy_q <= 1'b1;
      end else if (stop_det) begin
        busy_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_out_q <= 1'b0;
      sda_out_q <= 1'b0;
    end else begin
      rdata_q <= reg_rd ? rd_val : 8'h00;
      scl_oe_q <= scl_low_want;
      sda_oe_q <= sda_oe_d;
      scl_out_q <= 1'b0;
      sda_out_q <= 1'b0;
    end
  end

  assign reg_rdata = rdata_q;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;
  assign scl_out = scl_out_q;
  assign sda_out = sda_out_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  ctl_set_a: assert property (
    wr_set && reg_wdata[BIT_ACK_ASSERT] |=> ctl_q[BIT_ACK_ASSERT])
    else $error("set port did not set the acknowledge bit");

  ctl_clr_a: assert property (
    wr_clr |=> ctl_q[BIT_BUS_ENABLE] == ($past(ctl_q[BIT_BUS_ENABLE]) && !$past(reg_wdata[BIT_BUS_ENABLE])))
    else $error("clear port changed an unselected bit");

  flag_clr_a: assert property (
    wr_clr && reg_wdata[BIT_INT_FLAG] && !si_set |=> !si_q)
    else $error("flag not cleared by the clear port");

  code_read_a: assert property (
    reg_rd && (reg_addr == REG_CONDITION_CODE) && si_q |=> reg_rdata[7:3] == $past(code_q))
    else $error("status read does not show the latched code");

  low_zero_a: assert property (
    reg_rd && (reg_addr == REG_CONDITION_CODE) |=> reg_rdata[2:0] == 3'b000)
    else $error("status low bits not zero");

  hold_low_a: assert property (
    (st_q == ST_HOLD) && ($past(st_q) == ST_HOLD) |-> scl_oe_q)
    else $error("clock not held low while flagged");

  arb_tx_a: assert property (
    arb_tx_lost |=> lost_q && (st_q == ST_XFER))
    else $error("lost arbitration not taken at once");

  byte_end_a: assert property (
    fall && lost_q && (bit_q == ACK_BIT) |=> (st_q == ST_SLAVE) ##1 !cg.en)
    else $error("clocking went on past the lost byte");

  rx_lost_a: assert property (
    arb_rx_lost |-> ##[1:300] (st_q == ST_SLAVE))
    else $error("receiver kept clocking after losing");

  slave_quiet_a: assert property (
    (st_q == ST_SLAVE) && !si_q |=> !scl_oe_q)
    else $error("clock driven in a slave mode");

  arb_seen_c: cover property (arb_tx_lost ##[1:300] (st_q == ST_SLAVE));
  flag_set_c: cover property (si_set && (code_d == CODE_TX_DATA_ACK));
  stop_done_c: cover property (halt_done);

endmodule

// ---- testbench/bus_partner.sv ----
`timescale 1ns/1ps
module bus_partner (
  // Wire levels
  input wire logic scl,
  input wire logic sda,
  // Scenario controls
  input wire logic stretch,
  input wire logic steal,
  // Open-drain pulls, high means pulling low
  output logic scl_low,
  output logic sda_low
);
  int bitn = 0;
  initial scl_low = 1'b0;
  initial sda_low = 1'b0;
  // Start condition restarts the bit count
  always @(negedge sda) if (scl) bitn = 0;
  // Acknowledge low, or win the first byte by pulling data low from bit one
  always @(negedge scl) begin
    bitn = bitn + 1;
    if (steal)
      sda_low = (bitn >= 1 && bitn < 9);
    else
      sda_low = (bitn % 9 == 0);
  end
  // Hold clock low after each fall, longer than the programmed low time
  always @(negedge scl) if (stretch) begin
    scl_low = 1'b1;
    #1000 scl_low = 1'b0;
  end
endmodule

// ---- testbench/tb_i2c_arbitration_sync_control.sv ----
`timescale 1ns/1ps
module tb_i2c_arbitration_sync_control;
  import i2c_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic scl_out, scl_oe, sda_out, sda_oe, p_scl, p_sda;
  logic stretch = 1'b0;
  logic steal = 1'b0;
  logic [7:0] v;
  int miscompares = 0;
  int n_checks = 0;
  // Wired-and with pull-ups
  wire scl_w = (scl_oe ? scl_out : 1'b1) & ~p_scl;
  wire sda_w = (sda_oe ? sda_out : 1'b1) & ~p_sda;

  i2c_arbitration_sync_control u_i2c_arbitration_sync_control (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe)
  );
  bus_partner u_bus_partner (
    .scl(scl_w), .sda(sda_w), .stretch(stretch), .steal(steal), .scl_low(p_scl), .sda_low(p_sda)
  );

  always #25 clk = ~clk;

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Polls the flag; the block has no interrupt line
  task automatic code_is(input logic [7:0] exp);
    int n = 0;
    rd(REG_CONTROL_SET_PORT, v);
    while (v[BIT_INT_FLAG] !== 1'b1 && n < 3000) begin
      rd(REG_CONTROL_SET_PORT, v);
      n++;
    end
    if (n >= 3000) begin
      miscompares++;
    end
    rd(REG_CONDITION_CODE, v);
    chk(v, exp);
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rd(REG_CONDITION_CODE, v);
    chk(v, 8'hF8);
    @(posedge clk);
    #1;
    chk(reg_rdata, 8'h00);
    rd(REG_LOW_PERIOD_COUNT, v);
    chk(v, 8'h04);
    wr(REG_CONDITION_CODE, 8'h55);
    rd(REG_CONDITION_CODE, v);
    chk(v, 8'hF8);
    rd(4'hF, v);
    chk(v, 8'h00);
    wr(REG_CONTROL_SET_PORT, 8'h87);
    rd(REG_CONTROL_SET_PORT, v);
    chk(v, 8'h04);
    wr(REG_CONTROL_SET_PORT, 8'h40);
    rd(REG_CONTROL_SET_PORT, v);
    chk(v, 8'h44);
    wr(REG_CONTROL_CLEAR_PORT, 8'h04);
    rd(REG_CONTROL_SET_PORT, v);
    chk(v, 8'h40);
    rd(REG_CONTROL_CLEAR_PORT, v);
    chk(v, 8'h00);
    // Address and one data byte, then stop; second pass with a stretching slave
    for (int s = 0; s < 2; s++) begin
      stretch <= s[0];
      wr(REG_LOW_PERIOD_COUNT, 8'h06);
      wr(REG_HIGH_PERIOD_COUNT, 8'h05);
      wr(REG_CONTROL_SET_PORT, 8'h20);
      code_is(8'h08);
      repeat (100) @(posedge clk);
      chk({7'h00, scl_oe}, 8'h01);
      chk({6'h00, scl_out, sda_out}, 8'h00);
      rd(REG_CONDITION_CODE, v);
      chk(v, 8'h08);
      wr(REG_SHIFT_BYTE, 8'hA4);
      wr(REG_CONTROL_CLEAR_PORT, 8'h28);
      code_is(8'h18);
      wr(REG_SHIFT_BYTE, 8'h3C);
      wr(REG_CONTROL_CLEAR_PORT, 8'h08);
      code_is(8'h28);
      wr(REG_CONTROL_SET_PORT, 8'h10);
      wr(REG_CONTROL_CLEAR_PORT, 8'h08);
      repeat (200) @(posedge clk);
      rd(REG_CONTROL_SET_PORT, v);
      chk(v, 8'h40);
      chk({6'h00, scl_w, sda_w}, 8'h03);
    end
    // Another master wins; last, since that master never frees the bus
    stretch <= 1'b0;
    steal <= 1'b1;
    wr(REG_CONTROL_SET_PORT, 8'h20);
    code_is(8'h08);
    wr(REG_SHIFT_BYTE, 8'hA4);
    wr(REG_CONTROL_CLEAR_PORT, 8'h28);
    code_is(8'h38);
    wr(REG_CONTROL_CLEAR_PORT, 8'h08);
    repeat (300) @(posedge clk);
    chk({7'h00, scl_oe}, 8'h00);
    rd(REG_CONDITION_CODE, v);
    chk(v, 8'hF8);
    wrap_up();
  end

  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    wrap_up();
  end
endmodule
